// File: core/hsync_fine_delay.sv
// Purpose: delays the coarse horizontal sync by 0..3 two-clock steps
// Assumes: step code is stable for a whole line
// Notes:   tap zero is the undelayed input
`timescale 1ns/1ps
`default_nettype none
module hsync_fine_delay
	import rt_pin_pkg::*;
#(
	parameter int STEP = FINE_STEP_CLKS,
	parameter int MAXS = FINE_MAX_STEPS
) (
	input  wire logic       clock,
	input  wire logic       resetn,
	input  wire logic       sync_in,
	input  wire logic [1:0] step_sel,
	output logic            sync_out
);

	localparam int DEPTH = STEP * MAXS;

	logic [DEPTH:1] tap_reg;
	logic [DEPTH:0] taps;

	// tap zero is the input itself, so the flops and the input never share a driver
	assign taps = {tap_reg, sync_in};

	// one flop per stage of the delay chain
	genvar i;
	generate
		for (i = 1; i <= DEPTH; i++) begin : g_stage
			always_ff @(posedge clock or negedge resetn) begin
				if (!resetn)
					tap_reg[i] <= 1'b0;
				else
					tap_reg[i] <= taps[i-1];
			end
		end
	endgenerate

	// pick the tap two clocks per step further down
	always_comb begin
		sync_out = taps[STEP * step_sel];
	end

endmodule // hsync_fine_delay
`default_nettype wire

// File: core/rt_pin_select.sv
// Purpose: chooses and drives the first real-time status pin
// Assumes: clock is the line-locked clock; status inputs share it
// Notes:   registers reached by subaddress write/read port
`timescale 1ns/1ps
`default_nettype none
module rt_pin_select
	import rt_pin_pkg::*;
#(
	parameter int LINE_CLKS    = 1728,
	parameter int ACTIVE_START = 264,
	parameter int HCNT_W       = 11
) (
	input  wire logic       clock,
	input  wire logic       resetn,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_write,
	output logic [7:0]      reg_rdata,
	input  wire logic       hlock_std,
	input  wire logic       hlock_fast,
	input  wire logic       vlock,
	input  wire logic       colour_found,
	input  wire logic       adc_lsb,
	input  wire logic       vsync_in,
	output logic            realtime_out_pin_a,
	output logic            realtime_out_pin_a_oe
);

	// *****************************************************
	// constants derived from parameters
	// *****************************************************

	localparam int ACTIVE_CLKS = ACTIVE_PIXELS * CLKS_PER_PIXEL;
	localparam int ACTIVE_END  = ACTIVE_START + ACTIVE_CLKS;
	localparam int HALF_LINE   = LINE_CLKS / 2;
	localparam logic [HCNT_W-1:0] LAST_CLK   = HCNT_W'(LINE_CLKS - 1);
	localparam logic [HCNT_W-1:0] REF_START  = HCNT_W'(ACTIVE_START);
	localparam logic [HCNT_W-1:0] REF_END    = HCNT_W'(ACTIVE_END);
	localparam logic [HCNT_W-1:0] HALF_POINT = HCNT_W'(HALF_LINE);
	localparam logic [HCNT_W-1:0] HCNT_ZERO  = '0;
	localparam logic [8:0]        VCNT_ZERO  = 9'h000;
	localparam logic [8:0]        VCNT_ONE   = 9'h001;
	localparam logic [8:0]        VCNT_LAST  = 9'h1ff;

	// *****************************************************
	// register storage
	// *****************************************************

	logic [7:0] hsync_begin_pos;
	logic [7:0] hsync_stop_pos;
	logic [7:0] mode_delay_reg;
	logic [7:0] rt_select_reg;
	logic [7:0] port_ctrl_reg;
	logic [7:0] vstart_lo_reg;
	logic [7:0] vstop_lo_reg;
	logic [7:0] vctrl_reg;

	// *****************************************************
	// decoded fields
	// *****************************************************

	logic [3:0] source_sel;
	logic       pin_a_invert;
	logic [1:0] hsync_fine_delay;
	logic       lock_type_sel;
	logic [8:0] vert_gate_start_line;
	logic [8:0] vert_gate_stop_line;
	logic       vert_gate_phase_sel;

	// *****************************************************
	// timing state
	// *****************************************************

	logic [1:0]        ref_div_reg;
	logic              clock_ref_toggle;
	logic              clock_ref_half_toggle;
	logic [HCNT_W-1:0] hcount_reg;
	logic              line_start;
	logic              half_line;
	logic              line_active_ref;
	logic [7:0]        unit_count;
	logic              hsync_coarse_reg;
	logic              horiz_sync_out;
	logic              vsync_prev_reg;
	logic              vsync_rise;
	logic              vert_sync_out;
	logic [8:0]        vcount_reg;
	logic              field_parity_reg;
	logic              vert_gate;
	logic              field_ident;
	logic              gated_line_ref;

	// *****************************************************
	// lock flags and pin selection
	// *****************************************************

	logic horiz_lock_flag;
	logic vert_horiz_lock_flag;
	logic full_lock_colour_flag;
	logic chosen;
	logic drive_en;

	// *****************************************************
	// register write port
	// *****************************************************

	// write decode, one byte per subaddress
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			hsync_begin_pos <= REG_RESET;
			hsync_stop_pos  <= REG_RESET;
			mode_delay_reg  <= REG_RESET;
			rt_select_reg   <= REG_RESET;
			port_ctrl_reg   <= REG_RESET;
			vstart_lo_reg   <= REG_RESET;
			vstop_lo_reg    <= REG_RESET;
			vctrl_reg       <= REG_RESET;
		end else if (reg_write) begin
			case (reg_addr)
				OFS_HSYNC_BEGIN: hsync_begin_pos <= reg_wdata;
				OFS_HSYNC_STOP:  hsync_stop_pos  <= reg_wdata;
				OFS_MODE_DELAY:  mode_delay_reg  <= reg_wdata;
				OFS_RT_SELECT:   rt_select_reg   <= reg_wdata;
				OFS_PORT_CTRL:   port_ctrl_reg   <= reg_wdata;
				OFS_VSTART_LO:   vstart_lo_reg   <= reg_wdata;
				OFS_VSTOP_LO:    vstop_lo_reg    <= reg_wdata;
				OFS_VCTRL:       vctrl_reg       <= reg_wdata;
				default: ; // unmapped writes are dropped
			endcase
		end
	end

	// *****************************************************
	// register read port
	// *****************************************************

	// registered readback of the addressed byte
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			reg_rdata <= UNMAPPED_READ;
		else begin
			case (reg_addr)
				OFS_HSYNC_BEGIN: reg_rdata <= hsync_begin_pos;
				OFS_HSYNC_STOP:  reg_rdata <= hsync_stop_pos;
				OFS_MODE_DELAY:  reg_rdata <= mode_delay_reg;
				OFS_RT_SELECT:   reg_rdata <= rt_select_reg;
				OFS_PORT_CTRL:   reg_rdata <= port_ctrl_reg;
				OFS_VSTART_LO:   reg_rdata <= vstart_lo_reg;
				OFS_VSTOP_LO:    reg_rdata <= vstop_lo_reg;
				OFS_VCTRL:       reg_rdata <= vctrl_reg;
				default:         reg_rdata <= UNMAPPED_READ;
			endcase
		end
	end

	// field extraction
	assign source_sel       = rt_select_reg[SEL_MSB:SEL_LSB];
	assign pin_a_invert     = mode_delay_reg[INVERT_BIT];
	assign hsync_fine_delay = mode_delay_reg[FINE_MSB:FINE_LSB];
	assign lock_type_sel    = port_ctrl_reg[LOCK_TYPE_BIT];
	assign vert_gate_phase_sel  = vctrl_reg[VPHASE_BIT];

	// nine-bit line numbers, top bit from the shared control byte
	assign vert_gate_start_line = {vctrl_reg[VSTART_MSB_BIT], vstart_lo_reg};
	assign vert_gate_stop_line  = {vctrl_reg[VSTOP_MSB_BIT], vstop_lo_reg};

	// *****************************************************
	// clock reference toggles
	// *****************************************************

	// free running divider; bit 0 at half, bit 1 at quarter clock rate
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			ref_div_reg <= 2'h0;
		else
			ref_div_reg <= ref_div_reg + 2'h1;
	end

	assign clock_ref_toggle      = ref_div_reg[0];
	assign clock_ref_half_toggle = ref_div_reg[1];

	// *****************************************************
	// horizontal counter
	// *****************************************************

	// clock position within the line, wraps every line
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			hcount_reg <= HCNT_ZERO;
		else if (hcount_reg == LAST_CLK)
			hcount_reg <= HCNT_ZERO;
		else
			hcount_reg <= hcount_reg + HCNT_W'(1);
	end

	assign line_start = (hcount_reg == HCNT_ZERO);
	assign half_line  = (hcount_reg == HALF_POINT);

	// *****************************************************
	// line reference
	// *****************************************************

	// high over the active pixels of every line, blanking included
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			line_active_ref <= 1'b0;
		else if (hcount_reg == REF_START)
			line_active_ref <= 1'b1;
		else if (hcount_reg == REF_END)
			line_active_ref <= 1'b0;
	end

	// *****************************************************
	// horizontal sync
	// *****************************************************

	// position in eight-clock units
	assign unit_count = 8'(hcount_reg >> HSYNC_UNIT_SHIFT);

	// coarse sync between begin and stop units
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			hsync_coarse_reg <= 1'b0;
		else
			hsync_coarse_reg <= (unit_count >= hsync_begin_pos) &&
			                    (unit_count <  hsync_stop_pos);
	end

	// fine shift in two-clock steps
	hsync_fine_delay u_fine (
		.clock    (clock),
		.resetn   (resetn),
		.sync_in  (hsync_coarse_reg),
		.step_sel (hsync_fine_delay),
		.sync_out (horiz_sync_out)
	);

	// *****************************************************
	// vertical timing
	// *****************************************************

	// edge detector on the vertical sync from the decoder
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			vsync_prev_reg <= 1'b0;
		else
			vsync_prev_reg <= vsync_in;
	end

	assign vsync_rise    = vsync_in && !vsync_prev_reg;
	assign vert_sync_out = vsync_prev_reg;

	// line number, restarts at one on each vertical sync
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			vcount_reg <= VCNT_ZERO;
		else if (vsync_rise)
			vcount_reg <= VCNT_ONE;
		else if (line_start && vcount_reg != VCNT_LAST)
			vcount_reg <= vcount_reg + VCNT_ONE;
	end

	// field parity flips on each vertical sync
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			field_parity_reg <= 1'b0;
		else if (vsync_rise)
			field_parity_reg <= !field_parity_reg;
	end

	// gate window and field ident
	vert_window u_vwin (
		.clock            (clock),
		.resetn           (resetn),
		.line_count       (vcount_reg),
		.line_start       (line_start),
		.half_line        (half_line),
		.vert_gate_start_line (vert_gate_start_line),
		.vert_gate_stop_line  (vert_gate_stop_line),
		.vert_gate_phase_sel  (vert_gate_phase_sel),
		.field_parity     (field_parity_reg),
		.vert_gate        (vert_gate),
		.field_ident      (field_ident)
	);

	// line reference only inside the vertical gate
	assign gated_line_ref = line_active_ref & vert_gate;

	// *****************************************************
	// lock indicators
	// *****************************************************

	// standard or fast horizontal lock
	assign horiz_lock_flag = lock_type_sel ? hlock_fast
	                                       : hlock_std;

	assign vert_horiz_lock_flag  = vlock & horiz_lock_flag;
	assign full_lock_colour_flag = vert_horiz_lock_flag & colour_found;

	// *****************************************************
	// source selection
	// *****************************************************

	// reserved codes act as the low code, so a stray write cannot float the line
	always_comb begin
		chosen   = 1'b0;
		drive_en = 1'b1;
		case (source_sel)
			SEL_FLOAT:        drive_en = 1'b0;
			SEL_LOW:          chosen   = 1'b0;
			SEL_CLK_REF:      chosen   = clock_ref_toggle;
			SEL_CLK_REF_HALF: chosen   = clock_ref_half_toggle;
			SEL_HLOCK:        chosen   = horiz_lock_flag;
			SEL_VHLOCK:       chosen   = vert_horiz_lock_flag;
			SEL_FULL_LOCK:    chosen   = full_lock_colour_flag;
			SEL_LINE_REF:     chosen   = line_active_ref;
			SEL_HSYNC:        chosen   = horiz_sync_out;
			SEL_GATED_REF:    chosen   = gated_line_ref;
			SEL_VSYNC:        chosen   = vert_sync_out;
			SEL_VERT_GATE:        chosen   = vert_gate;
			SEL_ADC_LSB:      chosen   = adc_lsb;
			SEL_FIELD:        chosen   = field_ident;
			default:          chosen   = 1'b0;
		endcase
	end

	// *****************************************************
	// pin drive
	// *****************************************************

	// registered pin value with optional inversion
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			realtime_out_pin_a <= 1'b0;
		else
			realtime_out_pin_a <= chosen ^ pin_a_invert;
	end

	// output enable, low only for the float code
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			realtime_out_pin_a_oe <= 1'b0;
		else
			realtime_out_pin_a_oe <= drive_en;
	end

endmodule // rt_pin_select
`default_nettype wire

// File: core/vert_window.sv
// Purpose: vertical gate and field ident from line count and start/stop
// Assumes: line count and event pulses come from the same clock
// Notes:   phase select picks line start or mid-line as the gate switch point; field ident always switches at line start
`timescale 1ns/1ps
`default_nettype none
module vert_window
	import rt_pin_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       resetn,
	input  wire logic [8:0] line_count,
	input  wire logic       line_start,
	input  wire logic       half_line,
	input  wire logic [8:0] vert_gate_start_line,
	input  wire logic [8:0] vert_gate_stop_line,
	input  wire logic       vert_gate_phase_sel,
	input  wire logic       field_parity,
	output logic            vert_gate,
	output logic            field_ident
);

	logic switch_point;

	// switch on line start or half line per phase select
	assign switch_point = vert_gate_phase_sel ? half_line : line_start;

	// gate opens on the start line, closes on the stop line
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			vert_gate <= 1'b0;
		else if (switch_point && line_count == vert_gate_start_line)
			vert_gate <= 1'b1;
		else if (switch_point && line_count == vert_gate_stop_line)
			vert_gate <= 1'b0;
	end

	// field ident takes the new parity at the start line
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			field_ident <= 1'b0;
		else if (line_start && line_count == vert_gate_start_line)
			field_ident <= field_parity;
	end

endmodule // vert_window
`default_nettype wire

// File: pkg/rt_pin_pkg.sv
// Purpose: shared constants for the first real-time status pin selector
// Assumes: registers are byte wide and addressed by 8-bit subaddress
// Notes:   codes, offsets, field positions and horizontal timing constants shared by the logic
package rt_pin_pkg;

	// register subaddresses
	localparam logic [7:0] OFS_HSYNC_BEGIN = 8'h06;
	localparam logic [7:0] OFS_HSYNC_STOP  = 8'h07;
	localparam logic [7:0] OFS_MODE_DELAY  = 8'h11;
	localparam logic [7:0] OFS_RT_SELECT   = 8'h12;
	localparam logic [7:0] OFS_PORT_CTRL   = 8'h13;
	localparam logic [7:0] OFS_VSTART_LO   = 8'h15;
	localparam logic [7:0] OFS_VSTOP_LO    = 8'h16;
	localparam logic [7:0] OFS_VCTRL       = 8'h17;

	// reset value of every register
	localparam logic [7:0] REG_RESET       = 8'h00;
	localparam logic [7:0] UNMAPPED_READ   = 8'h00;

	// field positions
	localparam int SEL_LSB         = 0;
	localparam int SEL_MSB         = 3;
	localparam int INVERT_BIT      = 3;
	localparam int FINE_LSB        = 4;
	localparam int FINE_MSB        = 5;
	localparam int LOCK_TYPE_BIT   = 3;
	localparam int VSTART_MSB_BIT  = 0;
	localparam int VSTOP_MSB_BIT   = 1;
	localparam int VPHASE_BIT      = 2;

	// source select codes
	localparam logic [3:0] SEL_FLOAT       = 4'h0;
	localparam logic [3:0] SEL_LOW         = 4'h1;
	localparam logic [3:0] SEL_CLK_REF     = 4'h2;
	localparam logic [3:0] SEL_CLK_REF_HALF= 4'h3;
	localparam logic [3:0] SEL_HLOCK       = 4'h4;
	localparam logic [3:0] SEL_VHLOCK      = 4'h5;
	localparam logic [3:0] SEL_FULL_LOCK   = 4'h6;
	localparam logic [3:0] SEL_LINE_REF    = 4'h8;
	localparam logic [3:0] SEL_HSYNC       = 4'h9;
	localparam logic [3:0] SEL_GATED_REF   = 4'ha;
	localparam logic [3:0] SEL_VSYNC       = 4'hc;
	localparam logic [3:0] SEL_VERT_GATE       = 4'hd;
	localparam logic [3:0] SEL_ADC_LSB     = 4'he;
	localparam logic [3:0] SEL_FIELD       = 4'hf;

	// horizontal timing
	localparam int CLKS_PER_PIXEL  = 2;
	localparam int ACTIVE_PIXELS   = 720;
	localparam int HSYNC_UNIT_SHIFT= 3;  // eight clocks per unit
	localparam int FINE_STEP_CLKS  = 2;
	localparam int FINE_MAX_STEPS  = 3;

endpackage

// File: verification/line_timing_monitor.sv
// Purpose: downstream consumer of the status pin, measures its timing
// Assumes: a floated pin is pulled low at the receiver
// Notes:   all figures in clock cycles; a rising edge marks a start
`timescale 1ns/1ps
`default_nettype none
module line_timing_monitor (
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic        pin,
	input  wire logic        oe,
	output logic             rise,
	output logic [15:0]      period,
	output logic [15:0]      high_len,
	output logic [15:0]      rise_cnt
);
	logic        level;
	logic        last_reg;
	logic [15:0] since_reg;
	logic [15:0] hi_reg;

	assign level = pin & oe; // pull-down when floated

	// edge detection, spacing and width of pulses
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			last_reg <= 1'b0;
			rise <= 1'b0;
			since_reg <= 16'h0000;
			hi_reg <= 16'h0000;
			period <= 16'h0000;
			high_len <= 16'h0000;
			rise_cnt <= 16'h0000;
		end else begin
			last_reg <= level;
			rise <= level & !last_reg;
			since_reg <= (level & !last_reg) ? 16'h0001 : since_reg + 16'h0001;
			hi_reg <= level ? hi_reg + 16'h0001 : 16'h0000;
			if (level & !last_reg) period <= since_reg;
			if (level & !last_reg) rise_cnt <= rise_cnt + 16'h0001;
			if (!level & last_reg) high_len <= hi_reg;
		end
	end
endmodule // line_timing_monitor
`default_nettype wire

// File: verification/rt_pin_select_props.sv
// Purpose: port-level checks of the status pin selector
// Assumes: steering fields change only through the write strobe
// Notes:   keeps shadow copies of select, invert and lock type
`timescale 1ns/1ps
`default_nettype none
module rt_pin_select_props
	import rt_pin_pkg::*;
(
	input wire logic       clock,
	input wire logic       resetn,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_write,
	input wire logic       hlock_std,
	input wire logic       hlock_fast,
	input wire logic       vlock,
	input wire logic       colour_found,
	input wire logic       adc_lsb,
	input wire logic       vsync_in,
	input wire logic       realtime_out_pin_a,
	input wire logic       realtime_out_pin_a_oe
);
	logic [3:0] sel_reg;
	logic       inv_reg;
	logic       lt_reg;
	wire logic  pin = realtime_out_pin_a;
	wire logic  oe = realtime_out_pin_a_oe;

	// shadow of the fields that steer the pin
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			sel_reg <= 4'h0;
			inv_reg <= 1'b0;
			lt_reg <= 1'b0;
		end else if (reg_write) begin
			if (reg_addr == OFS_RT_SELECT) sel_reg <= reg_wdata[SEL_MSB:SEL_LSB];
			if (reg_addr == OFS_MODE_DELAY) inv_reg <= reg_wdata[INVERT_BIT];
			if (reg_addr == OFS_PORT_CTRL) lt_reg <= reg_wdata[LOCK_TYPE_BIT];
		end
	end

	// ****
	// properties
	// ****
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	// one cycle with a source selected and no register traffic
	sequence held(logic [3:0] code);
		sel_reg == code && !reg_write;
	endsequence

	a_float_oe: assert property (sel_reg == SEL_FLOAT |=> !oe)
		else $error("pin driven while floating");
	a_low_drive: assert property (sel_reg == SEL_LOW |=> oe && pin == $past(inv_reg))
		else $error("constant low level wrong");
	a_hlock_std: assert property (sel_reg == SEL_HLOCK && !lt_reg
		|=> pin == $past(hlock_std ^ inv_reg)) else $error("standard lock not on pin");
	a_hlock_fast: assert property (sel_reg == SEL_HLOCK && lt_reg
		|=> pin == $past(hlock_fast ^ inv_reg)) else $error("fast lock not on pin");
	a_both_lock: assert property (sel_reg == SEL_VHLOCK && hlock_std == hlock_fast
		|=> pin == $past((hlock_std & vlock) ^ inv_reg)) else $error("lock pair wrong");
	a_colour_lock: assert property (sel_reg == SEL_FULL_LOCK && hlock_std == hlock_fast
		|=> pin == $past((hlock_std & vlock & colour_found) ^ inv_reg))
		else $error("full lock flag wrong");
	a_adc_lsb: assert property (sel_reg == SEL_ADC_LSB |=> pin == $past(adc_lsb ^ inv_reg))
		else $error("converter bit not on pin");
	a_clk_toggle: assert property (held(SEL_CLK_REF)[*2] |=> pin != $past(pin))
		else $error("clock reference not toggling");
	a_half_toggle: assert property (held(SEL_CLK_REF_HALF)[*3] |=> pin != $past(pin, 2))
		else $error("half clock reference wrong");
	a_vsync_out: assert property (held(SEL_VSYNC)[*2]
		|=> pin == ($past(vsync_in, 2) ^ $past(inv_reg))) else $error("vertical sync wrong");
endmodule // rt_pin_select_props

bind rt_pin_select rt_pin_select_props rt_pin_select_props_inst (.clock(clock),
	.resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
	.hlock_std(hlock_std), .hlock_fast(hlock_fast), .vlock(vlock),
	.colour_found(colour_found), .adc_lsb(adc_lsb), .vsync_in(vsync_in),
	.realtime_out_pin_a(realtime_out_pin_a), .realtime_out_pin_a_oe(realtime_out_pin_a_oe));
`default_nettype wire

// File: verification/tb_top.sv
// Purpose: self-checking bench of the status pin selector
// Assumes: short line and field, three lines to a field
// Notes:   random lock inputs from a fixed-seed shift register
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import rt_pin_pkg::*;
;
	localparam logic [15:0] LINE = 16'h05a6;
	localparam logic [15:0] FIELD = 16'h10f2;
	logic        clock = 1'b0;
	logic        resetn = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_write = 1'b0;
	logic [4:0]  stat = 5'h00; // std, fast, vertical, colour, converter
	logic        vsync_in = 1'b0;
	logic [7:0]  reg_rdata;
	logic        pin;
	logic        oe;
	logic        rise;
	logic [15:0] period;
	logic [15:0] high_len;
	logic [15:0] rise_cnt;
	logic [31:0] rnd = 32'h00000d32;
	int          error_cnt = 0;
	int          checks = 0;
	int          vcnt = 0;
	logic [3:0]  codes [6] = '{SEL_FLOAT, SEL_LOW, SEL_HLOCK, SEL_VHLOCK, SEL_FULL_LOCK,
		SEL_ADC_LSB};
	logic [7:0]  addrs [8] = '{OFS_HSYNC_BEGIN, OFS_HSYNC_STOP, OFS_MODE_DELAY, OFS_RT_SELECT,
		OFS_PORT_CTRL, OFS_VSTART_LO, OFS_VSTOP_LO, OFS_VCTRL};

	rt_pin_select #(.LINE_CLKS(int'(LINE)), .ACTIVE_START(5), .HCNT_W(11)) rt_pin_select_inst (
		.clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_rdata(reg_rdata), .hlock_std(stat[4]),
		.hlock_fast(stat[3]), .vlock(stat[2]), .colour_found(stat[1]), .adc_lsb(stat[0]),
		.vsync_in(vsync_in), .realtime_out_pin_a(pin), .realtime_out_pin_a_oe(oe));
	line_timing_monitor line_timing_monitor_inst (.clock(clock), .resetn(resetn), .pin(pin),
		.oe(oe), .rise(rise), .period(period), .high_len(high_len), .rise_cnt(rise_cnt));

	// clock at 10 MHz
	initial begin
		forever #50 clock = ~clock;
	end

	// vertical sync, ten clocks high once per field
	always @(posedge clock) begin
		vcnt <= (vcnt == int'(FIELD) - 1) ? 0 : vcnt + 1;
		vsync_in <= (vcnt < 10);
	end

	// ****
	// helpers
	// ****
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// expected {enable, level} for the static sources
	function automatic logic [1:0] exp_pin(input logic [3:0] c, input logic [4:0] s,
		input logic [1:0] m);
		logic h;
		h = m[1] ? s[3] : s[4];
		case (c)
			SEL_FLOAT: return 2'b00;
			SEL_HLOCK: return {1'b1, h ^ m[0]};
			SEL_VHLOCK: return {1'b1, (h & s[2]) ^ m[0]};
			SEL_FULL_LOCK: return {1'b1, (h & s[2] & s[1]) ^ m[0]};
			SEL_ADC_LSB: return {1'b1, s[0] ^ m[0]};
			default: return {1'b1, m[0]};
		endcase
	endfunction

	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_pin(input logic [1:0] got, input logic [1:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clock);
		reg_addr <= a;
		@(posedge clock);
		@(negedge clock);
		chk_val({8'h00, reg_rdata}, {8'h00, e});
	endtask

	task automatic wait_rise();
		int n;
		n = 0;
		do begin
			@(negedge clock); // monitor outputs settled, away from the launching edge
			n++;
		end while (rise !== 1'b1 && n < 20000);
		chk_val({15'h0000, rise}, 16'h0001);
	endtask

	task automatic meas(input logic [3:0] c, input logic [15:0] hi, input logic [15:0] per);
		wr(OFS_RT_SELECT, {4'h0, c});
		repeat (3) wait_rise();
		chk_val(high_len, hi);
		chk_val(period, per);
	endtask

	task automatic count_field(input logic [3:0] c, input logic [15:0] n);
		logic [15:0] c0;
		wr(OFS_RT_SELECT, {4'h0, c});
		repeat (2) wait_rise();
		c0 = rise_cnt;
		repeat (int'(FIELD)) @(posedge clock);
		@(negedge clock);
		chk_val(rise_cnt - c0, n);
	endtask

	task automatic finish_test();
		$display("checks=%0d error_cnt=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// watchdog
	initial begin
		repeat (120000) @(posedge clock);
		error_cnt++;
		finish_test();
	end

	// ****
	// scenarios
	// ****
	initial begin
		logic [4:0] s;
		logic [7:0] d;
		logic [1:0] cur;
		logic [1:0] prev;
		repeat (8) @(posedge clock);
		resetn <= 1'b1;
		foreach (addrs[k]) rd_chk(addrs[k], REG_RESET);
		foreach (addrs[k]) begin
			rnd = lfsr(rnd);
			d = rnd[7:0];
			if (addrs[k] == OFS_RT_SELECT) d[3:0] = SEL_LINE_REF;
			wr(addrs[k], d);
			rd_chk(addrs[k], d);
		end
		wr(8'h20, 8'hff);
		rd_chk(8'h20, UNMAPPED_READ);
		for (int i = 0; i < 6; i++) begin
			for (int m = 0; m < 4; m++) begin
				wr(OFS_MODE_DELAY, {4'h0, m[0], 3'h0});
				wr(OFS_PORT_CTRL, {4'h0, m[1], 3'h0});
				wr(OFS_RT_SELECT, {4'h0, codes[i]});
				repeat (6) begin
					@(posedge clock);
					rnd = lfsr(rnd);
					s = rnd[4:0];
					if (codes[i] inside {SEL_VHLOCK, SEL_FULL_LOCK}) s[3] = s[4];
					stat <= s;
					@(posedge clock);
					@(negedge clock);
					chk_pin({oe, pin & oe}, exp_pin(codes[i], s, 2'(m)));
				end
			end
		end
		wr(OFS_MODE_DELAY, 8'h00);
		meas(SEL_CLK_REF, 16'h0001, 16'h0002);
		meas(SEL_CLK_REF_HALF, 16'h0002, 16'h0004);
		meas(SEL_LINE_REF, 16'(ACTIVE_PIXELS * CLKS_PER_PIXEL), LINE);
		count_field(SEL_LINE_REF, 16'h0003);
		wr(OFS_HSYNC_BEGIN, 8'h02);
		wr(OFS_HSYNC_STOP, 8'h05);
		meas(SEL_HSYNC, 16'(3 << HSYNC_UNIT_SHIFT), LINE);
		prev = 2'h0;
		for (int f = 1; f < 5; f++) begin
			cur = 2'(f);
			wait_rise();
			repeat (50) @(posedge clock);
			wr(OFS_MODE_DELAY, {2'h0, cur, 4'h0});
			wait_rise();
			chk_val(period, LINE + 16'(FINE_STEP_CLKS * (int'(cur) - int'(prev))));
			prev = cur;
		end
		wr(OFS_VSTART_LO, 8'h02);
		wr(OFS_VSTOP_LO, 8'h03);
		wr(OFS_VCTRL, 8'h00);
		meas(SEL_VERT_GATE, LINE, FIELD);
		count_field(SEL_GATED_REF, 16'h0001);
		meas(SEL_VSYNC, 16'h000a, FIELD);
		meas(SEL_FIELD, FIELD, 16'(2 * FIELD));
		finish_test();
	end
endmodule // tb_top
`default_nettype wire
